/* rcr_pkg.sv */
package rcr_pkg;

   // Register addresses on the host register port.
   localparam logic [7:0] OFS_CONV_A_LIMIT_SLEW  = 8'h03;
   localparam logic [7:0] OFS_CONV_B_MODE_ENABLE = 8'h04;
   localparam logic [7:0] OFS_CONV_B_LIMIT_SLEW  = 8'h05;
   localparam logic [7:0] OFS_CONV_A_VOLTAGE     = 8'h06;
   localparam logic [7:0] OFS_CONV_B_VOLTAGE     = 8'h07;
   localparam logic [7:0] OFS_LINEAR_A_CONTROL   = 8'h08;
   localparam logic [7:0] OFS_LINEAR_B_CONTROL   = 8'h09;

   // Field positions.
   localparam int LIMIT_MSB   = 5;
   localparam int LIMIT_LSB   = 3;
   localparam int RAMP_MSB    = 2;
   localparam int RAMP_LSB    = 0;
   localparam int FPWM_BIT    = 3;
   localparam int DISCHG_BIT  = 2;
   localparam int PINGATE_BIT = 1;
   localparam int ON_BIT      = 0;

   // Writable bits of each register except the voltage registers, which take all eight bits; reserved bits hold zero.
   localparam logic [7:0] LIMIT_SLEW_MASK  = 8'h3F;
   localparam logic [7:0] MODE_ENABLE_MASK = 8'h0F;
   localparam logic [7:0] LINEAR_MASK      = 8'h07;

   // Reset values.
   localparam logic [7:0] LIMIT_SLEW_RST  = 8'h00;
   localparam logic [7:0] MODE_ENABLE_RST = 8'h04;
   localparam logic [7:0] VOLTAGE_RST     = 8'h00;
   localparam logic [7:0] LINEAR_RST      = 8'h04;

   // Current limit in mA: base plus step per code.
   localparam logic [11:0] LIMIT_BASE_MA  = 12'h5DC;
   localparam logic [11:0] LIMIT_STEP_MA  = 12'h1F4;
   localparam logic [2:0]  LIMIT_MAX_CODE = 3'h5;

   // Ramp rate in units of 10 uV/us, codes 2 to 7.
   localparam logic [2:0] RAMP_MIN_CODE = 3'h2;
   localparam logic [9:0] RAMP_CODE2    = 10'h3E8;
   localparam logic [9:0] RAMP_CODE3    = 10'h2EE;
   localparam logic [9:0] RAMP_CODE4    = 10'h17C;
   localparam logic [9:0] RAMP_CODE5    = 10'h0BE;
   localparam logic [9:0] RAMP_CODE6    = 10'h05E;
   localparam logic [9:0] RAMP_CODE7    = 10'h02F;

   // Output voltage segments in mV.
   localparam logic [7:0]  VOLT_SEG1_CODE = 8'h14;
   localparam logic [7:0]  VOLT_SEG2_CODE = 8'h18;
   localparam logic [7:0]  VOLT_SEG3_CODE = 8'h9E;
   localparam logic [11:0] VOLT_SEG1_MV   = 12'h2BC;
   localparam logic [11:0] VOLT_SEG2_MV   = 12'h2DF;
   localparam logic [11:0] VOLT_SEG3_MV   = 12'h58C;
   localparam logic [11:0] VOLT_SEG1_STEP = 12'h00A;
   localparam logic [11:0] VOLT_SEG2_STEP = 12'h005;
   localparam logic [11:0] VOLT_SEG3_STEP = 12'h014;

endpackage

/* rcr_regs.sv */
`timescale 1ns/1ps
module rcr_regs (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        enPin,
   input  wire logic [7:0]  regAddr,
   input  wire logic        regWrEn,
   input  wire logic [7:0]  regWrData,
   output logic      [7:0]  regRdData,
   output logic      [11:0] convACurrentLimitMa,
   output logic      [9:0]  convARampRate,
   output logic      [11:0] convAVoltageMv,
   output logic             convACodeReserved,
   output logic      [11:0] convBCurrentLimitMa,
   output logic      [9:0]  convBRampRate,
   output logic      [11:0] convBVoltageMv,
   output logic             convBCodeReserved,
   output logic             convBForcedPulseWidth,
   output logic             convBRun,
   output logic             convBDischarge,
   output logic             linARun,
   output logic             linADischarge,
   output logic             linBRun,
   output logic             linBDischarge
);

   ////////////////////////////////////////////////////////////////////////////////
   // Decode functions.

   function automatic logic [11:0] limitMa(input logic [2:0] code);
      limitMa = 12'(rcr_pkg::LIMIT_BASE_MA + 12'(rcr_pkg::LIMIT_STEP_MA * {9'h000, code}));
   endfunction

   function automatic logic [9:0] rampRate(input logic [2:0] code);
      logic [9:0] r;
      r = 10'h000;
      case (code)
         3'h2: r = rcr_pkg::RAMP_CODE2;
         3'h3: r = rcr_pkg::RAMP_CODE3;
         3'h4: r = rcr_pkg::RAMP_CODE4;
         3'h5: r = rcr_pkg::RAMP_CODE5;
         3'h6: r = rcr_pkg::RAMP_CODE6;
         3'h7: r = rcr_pkg::RAMP_CODE7;
         default: r = 10'h000;
      endcase
      rampRate = r;
   endfunction

   function automatic logic [11:0] voltMv(input logic [7:0] code);
      logic [11:0] w;
      w = {4'h0, code};
      if (code < rcr_pkg::VOLT_SEG1_CODE) begin
         voltMv = 12'h000;
      end else if (code < rcr_pkg::VOLT_SEG2_CODE) begin
         voltMv = 12'(rcr_pkg::VOLT_SEG1_MV + 12'(rcr_pkg::VOLT_SEG1_STEP
                  * 12'(w - {4'h0, rcr_pkg::VOLT_SEG1_CODE})));
      end else if (code < rcr_pkg::VOLT_SEG3_CODE) begin
         voltMv = 12'(rcr_pkg::VOLT_SEG2_MV + 12'(rcr_pkg::VOLT_SEG2_STEP
                  * 12'(w - {4'h0, rcr_pkg::VOLT_SEG2_CODE})));
      end else begin
         voltMv = 12'(rcr_pkg::VOLT_SEG3_MV + 12'(rcr_pkg::VOLT_SEG3_STEP
                  * 12'(w - {4'h0, rcr_pkg::VOLT_SEG3_CODE})));
      end
   endfunction

   function automatic logic codeBad(input logic [7:0] limSlew, input logic [7:0] volt);
      codeBad = (limSlew[rcr_pkg::LIMIT_MSB:rcr_pkg::LIMIT_LSB] > rcr_pkg::LIMIT_MAX_CODE)
             || (limSlew[rcr_pkg::RAMP_MSB:rcr_pkg::RAMP_LSB] < rcr_pkg::RAMP_MIN_CODE)
             || (volt < rcr_pkg::VOLT_SEG1_CODE);
   endfunction

   function automatic logic runs(input logic [7:0] ctl, input logic pin);
      runs = ctl[rcr_pkg::ON_BIT] & (~ctl[rcr_pkg::PINGATE_BIT] | pin);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Enable pin synchroniser.

   logic enMeta_r;
   logic enSync_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         enMeta_r <= 1'b0;
         enSync_r <= 1'b0;
      end else begin
         enMeta_r <= enPin;
         enSync_r <= enMeta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register file.

   logic [7:0] convALimSlew_r;
   logic [7:0] convBModeEn_r;
   logic [7:0] convBLimSlew_r;
   logic [7:0] convAVolt_r;
   logic [7:0] convBVolt_r;
   logic [7:0] linACtl_r;
   logic [7:0] linBCtl_r;

   wire wrALimSlew = regWrEn && (regAddr == rcr_pkg::OFS_CONV_A_LIMIT_SLEW);
   wire wrBModeEn  = regWrEn && (regAddr == rcr_pkg::OFS_CONV_B_MODE_ENABLE);
   wire wrBLimSlew = regWrEn && (regAddr == rcr_pkg::OFS_CONV_B_LIMIT_SLEW);
   wire wrAVolt    = regWrEn && (regAddr == rcr_pkg::OFS_CONV_A_VOLTAGE);
   wire wrBVolt    = regWrEn && (regAddr == rcr_pkg::OFS_CONV_B_VOLTAGE);
   wire wrLinA     = regWrEn && (regAddr == rcr_pkg::OFS_LINEAR_A_CONTROL);
   wire wrLinB     = regWrEn && (regAddr == rcr_pkg::OFS_LINEAR_B_CONTROL);

   // Limit fields are taken whenever written, running or not.
   always_ff @(posedge clk) begin
      if (reset) begin
         convALimSlew_r <= rcr_pkg::LIMIT_SLEW_RST;
         convBModeEn_r  <= rcr_pkg::MODE_ENABLE_RST;
         convBLimSlew_r <= rcr_pkg::LIMIT_SLEW_RST;
         convAVolt_r    <= rcr_pkg::VOLTAGE_RST;
         convBVolt_r    <= rcr_pkg::VOLTAGE_RST;
         linACtl_r      <= rcr_pkg::LINEAR_RST;
         linBCtl_r      <= rcr_pkg::LINEAR_RST;
      end else begin
         if (wrALimSlew) convALimSlew_r <= regWrData & rcr_pkg::LIMIT_SLEW_MASK;
         if (wrBModeEn)  convBModeEn_r  <= regWrData & rcr_pkg::MODE_ENABLE_MASK;
         if (wrBLimSlew) convBLimSlew_r <= regWrData & rcr_pkg::LIMIT_SLEW_MASK;
         if (wrAVolt)    convAVolt_r    <= regWrData;
         if (wrBVolt)    convBVolt_r    <= regWrData;
         if (wrLinA)     linACtl_r      <= regWrData & rcr_pkg::LINEAR_MASK;
         if (wrLinB)     linBCtl_r      <= regWrData & rcr_pkg::LINEAR_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path; unmapped addresses read zero.

   logic [7:0] rdMux;

   always_comb begin
      rdMux = 8'h00;
      unique case (regAddr)
         rcr_pkg::OFS_CONV_A_LIMIT_SLEW:  rdMux = convALimSlew_r;
         rcr_pkg::OFS_CONV_B_MODE_ENABLE: rdMux = convBModeEn_r;
         rcr_pkg::OFS_CONV_B_LIMIT_SLEW:  rdMux = convBLimSlew_r;
         rcr_pkg::OFS_CONV_A_VOLTAGE:     rdMux = convAVolt_r;
         rcr_pkg::OFS_CONV_B_VOLTAGE:     rdMux = convBVolt_r;
         rcr_pkg::OFS_LINEAR_A_CONTROL:   rdMux = linACtl_r;
         rcr_pkg::OFS_LINEAR_B_CONTROL:   rdMux = linBCtl_r;
         default:                         rdMux = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         regRdData <= 8'h00;
      end else begin
         regRdData <= rdMux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Decoded regulator controls.

   wire convBOn   = runs(convBModeEn_r, enSync_r);
   wire linAOn    = runs(linACtl_r, enSync_r);
   wire linBOn    = runs(linBCtl_r, enSync_r);
   wire [2:0] convALimCode  = convALimSlew_r[rcr_pkg::LIMIT_MSB:rcr_pkg::LIMIT_LSB];
   wire [2:0] convARampCode = convALimSlew_r[rcr_pkg::RAMP_MSB:rcr_pkg::RAMP_LSB];
   wire [2:0] convBLimCode  = convBLimSlew_r[rcr_pkg::LIMIT_MSB:rcr_pkg::LIMIT_LSB];
   wire [2:0] convBRampCode = convBLimSlew_r[rcr_pkg::RAMP_MSB:rcr_pkg::RAMP_LSB];

   always_ff @(posedge clk) begin
      if (reset) begin
         convACurrentLimitMa   <= 12'h000;
         convARampRate         <= 10'h000;
         convAVoltageMv        <= 12'h000;
         convACodeReserved     <= 1'b0;
         convBCurrentLimitMa   <= 12'h000;
         convBRampRate         <= 10'h000;
         convBVoltageMv        <= 12'h000;
         convBCodeReserved     <= 1'b0;
         convBForcedPulseWidth <= 1'b0;
         convBRun              <= 1'b0;
         convBDischarge        <= 1'b0;
         linARun               <= 1'b0;
         linADischarge         <= 1'b0;
         linBRun               <= 1'b0;
         linBDischarge         <= 1'b0;
      end else begin
         convACurrentLimitMa   <= limitMa(convALimCode);
         convARampRate         <= rampRate(convARampCode);
         convAVoltageMv        <= voltMv(convAVolt_r);
         convACodeReserved     <= codeBad(convALimSlew_r, convAVolt_r);
         convBCurrentLimitMa   <= limitMa(convBLimCode);
         convBRampRate         <= rampRate(convBRampCode);
         convBVoltageMv        <= voltMv(convBVolt_r);
         convBCodeReserved     <= codeBad(convBLimSlew_r, convBVolt_r);
         convBForcedPulseWidth <= convBModeEn_r[rcr_pkg::FPWM_BIT];
         convBRun              <= convBOn;
         convBDischarge        <= convBModeEn_r[rcr_pkg::DISCHG_BIT] & ~convBOn;
         linARun               <= linAOn;
         linADischarge         <= linACtl_r[rcr_pkg::DISCHG_BIT] & ~linAOn;
         linBRun               <= linBOn;
         linBDischarge         <= linBCtl_r[rcr_pkg::DISCHG_BIT] & ~linBOn;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_readback_voltage: assert property (
      (regWrEn && regAddr == rcr_pkg::OFS_CONV_A_VOLTAGE)
      ##1 (!regWrEn && regAddr == rcr_pkg::OFS_CONV_A_VOLTAGE)
      |=> regRdData == $past(regWrData, 2))
      else $error("Voltage register did not read back the written value.");

   a_limit_map: assert property (
      (wrALimSlew && regWrData[5:3] <= 3'h5)
      |=> ##1 convACurrentLimitMa == 12'(12'h5DC + 12'h1F4 * {9'h000, $past(regWrData[5:3], 2)}))
      else $error("Converter A current limit does not follow its code.");

   a_limit_live: assert property (
      (convBRun && wrBLimSlew && regWrData[5:3] == 3'h5 && !$stable(convBLimSlew_r[5:3]) == 1'b0)
      |=> ##1 convBCurrentLimitMa == 12'hFA0)
      else $error("Converter B limit change not applied while running.");

   a_ramp_fast: assert property (
      (wrALimSlew && regWrData[2:0] == 3'h2) |=> ##1 convARampRate == 10'h3E8)
      else $error("Converter A fastest ramp code decoded wrongly.");

   a_ramp_slow_b: assert property (
      (wrBLimSlew && regWrData[2:0] == 3'h7) |=> ##1 convBRampRate == 10'h02F)
      else $error("Converter B slowest ramp code decoded wrongly.");

   a_volt_low_seg: assert property (
      (wrBVolt && regWrData == 8'h17) |=> ##1 convBVoltageMv == 12'h2DA)
      else $error("Voltage code 0x17 is not 730 mV.");

   a_volt_mid_seg: assert property (
      (wrAVolt && regWrData == 8'h9D) |=> ##1 convAVoltageMv == 12'h578)
      else $error("Voltage code 0x9D is not 1400 mV.");

   a_volt_top_seg: assert property (
      (wrAVolt && regWrData == 8'hFF) |=> ##1 convAVoltageMv == 12'hD20)
      else $error("Voltage code 0xFF is not 3360 mV.");

   a_pwm_mode: assert property (
      ##1 convBForcedPulseWidth == $past(convBModeEn_r[3]))
      else $error("Forced PWM output does not follow its bit.");

   a_discharge_off: assert property (
      convBDischarge |-> !convBRun && $past(convBModeEn_r[2]))
      else $error("Converter B discharge active while running or not selected.");

   a_pin_gating: assert property (
      (convBModeEn_r[1:0] == 2'h3 && !enSync_r) |=> !convBRun)
      else $error("Converter B ran with pin gating and the pin low.");

   a_bit_only: assert property (
      (convBModeEn_r[1:0] == 2'h1) |=> convBRun)
      else $error("Converter B not running with enable set and no gating.");

   a_linear_a_run: assert property (
      ##1 linARun == $past(linACtl_r[0] & (~linACtl_r[1] | enSync_r)))
      else $error("Linear A run does not follow enable and pin.");

   a_linear_dischg: assert property (
      (linACtl_r[2] && !linAOn) |=> linADischarge)
      else $error("Linear A discharge missing while disabled.");

   a_ramp_reserved: assert property (
      (wrALimSlew && regWrData[2:0] < 3'h2) |=> ##1 convARampRate == 10'h000)
      else $error("Converter A reserved ramp code not decoded as zero.");

   a_limit_base_b: assert property (
      (wrBLimSlew && regWrData[5:3] == 3'h0) |=> ##1 convBCurrentLimitMa == 12'h5DC)
      else $error("Converter B lowest limit code is not 1500 mA.");

   a_volt_reserved: assert property (
      (wrBVolt && regWrData < 8'h14) |=> ##1 convBCodeReserved)
      else $error("Converter B reserved voltage code not flagged.");

   a_mode_readback: assert property (
      (wrBModeEn ##1 (!regWrEn && regAddr == rcr_pkg::OFS_CONV_B_MODE_ENABLE))
      |=> regRdData == ($past(regWrData, 2) & 8'h0F))
      else $error("Mode register did not read back the written value.");

endmodule

/* regulator_control_registers_tb.sv */
`timescale 1ns/1ps
module regulator_control_registers_tb;
   logic        clk;
   logic        reset;
   logic        enPin;
   logic [7:0]  regAddr;
   logic        regWrEn;
   logic [7:0]  regWrData;
   logic [7:0]  regRdData;
   logic [11:0] convACurrentLimitMa;
   logic [9:0]  convARampRate;
   logic [11:0] convAVoltageMv;
   logic        convACodeReserved;
   logic [11:0] convBCurrentLimitMa;
   logic [9:0]  convBRampRate;
   logic [11:0] convBVoltageMv;
   logic        convBCodeReserved;
   logic        convBForcedPulseWidth;
   logic        convBRun;
   logic        convBDischarge;
   logic        linARun;
   logic        linADischarge;
   logic        linBRun;
   logic        linBDischarge;
   int          errCount;
   int          checked;
   logic [9:0]  rampTab [8] = '{10'h000, 10'h000, 10'h3E8, 10'h2EE,
                                10'h17C, 10'h0BE, 10'h05E, 10'h02F};
   logic [7:0]  voltTab [7] = '{8'h13, 8'h14, 8'h17, 8'h18, 8'h9D, 8'h9E, 8'hFF};

   rcr_regs dut (
      .clk                   (clk),
      .reset                 (reset),
      .enPin                 (enPin),
      .regAddr               (regAddr),
      .regWrEn               (regWrEn),
      .regWrData             (regWrData),
      .regRdData             (regRdData),
      .convACurrentLimitMa   (convACurrentLimitMa),
      .convARampRate         (convARampRate),
      .convAVoltageMv        (convAVoltageMv),
      .convACodeReserved     (convACodeReserved),
      .convBCurrentLimitMa   (convBCurrentLimitMa),
      .convBRampRate         (convBRampRate),
      .convBVoltageMv        (convBVoltageMv),
      .convBCodeReserved     (convBCodeReserved),
      .convBForcedPulseWidth (convBForcedPulseWidth),
      .convBRun              (convBRun),
      .convBDischarge        (convBDischarge),
      .linARun               (linARun),
      .linADischarge         (linADischarge),
      .linBRun               (linBRun),
      .linBDischarge         (linBDischarge)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and shared tasks.
   initial clk = 1'b0;
   always #4 clk = ~clk;

   function automatic logic [11:0] vexp(input logic [7:0] c);
      if (c < 8'h14) return 12'h000;
      if (c < 8'h18) return 12'h2BC + 12'h00A * {4'h0, c - 8'h14};
      if (c < 8'h9E) return 12'h2DF + 12'h005 * {4'h0, c - 8'h18};
      return 12'h58C + 12'h014 * {4'h0, c - 8'h9E};
   endfunction

   task automatic final_report;
      $display("checked %0d mismatches %0d", checked, errCount);
      if (errCount == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      checked++;
      if (got !== exp) begin
         errCount++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // A write is taken at the next rising edge; the task returns after the
   // decoded outputs have followed it.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clk);
      regWrEn = 1'b0;
      @(negedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      regAddr = a;
      @(negedge clk);
      chk(name, {4'h0, exp}, {4'h0, regRdData});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog that cuts a hang short.
   initial begin
      repeat (20000) @(posedge clk);
      errCount++;
      $display("[FAIL] watchdog expected finish seen timeout");
      final_report();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      logic [11:0] lim;
      logic        run;
      logic [3:0]  mode;
      reset = 1'b1;
      enPin = 1'b0;
      regAddr = 8'h00;
      regWrEn = 1'b0;
      regWrData = 8'h00;
      errCount = 0;
      checked = 0;
      repeat (16) @(negedge clk);
      reset = 1'b0;
      rd(8'h03, rcr_pkg::LIMIT_SLEW_RST, "rstLimitSlewA");
      rd(8'h04, 8'h04, "rstModeEnableB");
      rd(8'h05, rcr_pkg::LIMIT_SLEW_RST, "rstLimitSlewB");
      rd(8'h06, rcr_pkg::VOLTAGE_RST, "rstVoltA");
      rd(8'h07, rcr_pkg::VOLTAGE_RST, "rstVoltB");
      rd(8'h08, 8'h04, "rstLinearA");
      rd(8'h09, rcr_pkg::LINEAR_RST, "rstLinearB");
      wr(8'h03, 8'hFF);
      rd(8'h03, 8'h3F, "resvBitsA");
      wr(8'h04, 8'hF0);
      rd(8'h04, 8'h00, "resvBitsModeB");
      wr(8'h08, 8'hF8);
      rd(8'h08, 8'h00, "resvBitsLinA");
      wr(8'h0A, 8'h5A);
      rd(8'h0A, 8'h00, "unmapped");
      // Every limit and ramp code on both converters, voltage held valid.
      wr(8'h06, 8'h9D);
      wr(8'h07, 8'h9D);
      for (int i = 0; i < 8; i++) begin
         wr(8'h03, {2'h0, 3'(i), 3'(i)});
         wr(8'h05, {2'h0, 3'(i), 3'(i)});
         lim = 12'h5DC + 12'h1F4 * 12'(i);
         chk("limitA", lim, convACurrentLimitMa);
         chk("limitB", lim, convBCurrentLimitMa);
         chk("rampA", {2'b00, rampTab[i]}, {2'b00, convARampRate});
         chk("rampB", {2'b00, rampTab[i]}, {2'b00, convBRampRate});
         chk("resvA", {11'h000, i < 2 || i > 5}, {11'h000, convACodeReserved});
         chk("resvB", {11'h000, i < 2 || i > 5}, {11'h000, convBCodeReserved});
         rd(8'h05, {2'b00, 3'(i), 3'(i)}, "readLimitSlewB");
      end
      // Voltage segment boundaries on both converters.
      wr(8'h03, 8'h12);
      wr(8'h05, 8'h12);
      for (int i = 0; i < 7; i++) begin
         wr(8'h06, voltTab[i]);
         wr(8'h07, voltTab[i]);
         chk("voltA", vexp(voltTab[i]), convAVoltageMv);
         chk("voltB", vexp(voltTab[i]), convBVoltageMv);
         chk("voltResv", {11'h000, voltTab[i] < 8'h14}, {11'h000, convACodeReserved});
         chk("voltResvB", {11'h000, voltTab[i] < 8'h14}, {11'h000, convBCodeReserved});
         rd(8'h07, voltTab[i], "readVoltB");
      end
      // Every mode, discharge, gating and enable setting against the pin.
      for (int k = 0; k < 32; k++) begin
         mode = 4'(k);
         enPin = k[4];
         wr(8'h04, {4'h0, mode});
         wr(8'h08, {5'h00, mode[2:0]});
         wr(8'h09, {5'h00, mode[2:0]});
         run = mode[0] & (~mode[1] | k[4]);
         chk("fpwmB", {11'h000, mode[3]}, {11'h000, convBForcedPulseWidth});
         chk("runB", {11'h000, run}, {11'h000, convBRun});
         chk("dischB", {11'h000, mode[2] & ~run}, {11'h000, convBDischarge});
         chk("runLinA", {11'h000, run}, {11'h000, linARun});
         chk("dischLinA", {11'h000, mode[2] & ~run}, {11'h000, linADischarge});
         chk("runLinB", {11'h000, run}, {11'h000, linBRun});
         chk("dischLinB", {11'h000, mode[2] & ~run}, {11'h000, linBDischarge});
      end
      // Limit change while converter B runs, then pin drop.
      enPin = 1'b1;
      wr(8'h04, 8'h03);
      wr(8'h05, 8'h12);
      chk("liveLimit", 12'h9C4, convBCurrentLimitMa);
      wr(8'h05, 8'h2A);
      chk("liveLimit", 12'hFA0, convBCurrentLimitMa);
      chk("liveRun", 12'h001, {11'h000, convBRun});
      enPin = 1'b0;
      repeat (4) @(negedge clk);
      chk("pinDrop", 12'h000, {11'h000, convBRun});
      final_report();
   end
endmodule
